// file: rtl/port_six_pkg.sv
// constants and types shared by the port six block
package port_six_pkg;

  // ***************************************************************
  // widths and line positions
  // ***************************************************************
  localparam int unsigned WIDTH     = 8;
  localparam int unsigned CS_LINES  = 5;
  localparam int unsigned ADDR_W    = 4;
  localparam int unsigned LINE_REL  = 5;
  localparam int unsigned LINE_ACK  = 6;
  localparam int unsigned LINE_WANT = 7;

  // ***************************************************************
  // register indices
  // ***************************************************************
  localparam logic [ADDR_W-1:0] OFS_DATA   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_DIR    = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_ODSEL  = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_STRAP  = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [WIDTH-1:0] RST_DATA  = 8'h00;
  localparam logic [WIDTH-1:0] RST_DIR   = 8'h00;
  localparam logic [WIDTH-1:0] RST_ODSEL = 8'h00;
  localparam logic [1:0]       RST_SEL   = 2'h2;

  // ***************************************************************
  // select count codes
  // ***************************************************************
  typedef enum logic [1:0] {
    SEL_THREE = 2'b00,
    SEL_TWO   = 2'b01,
    SEL_NONE  = 2'b10,
    SEL_FIVE  = 2'b11
  } select_count_field_t;

  // ***************************************************************
  // release tracking states
  // ***************************************************************
  typedef enum logic [1:0] {
    ST_OWN   = 2'b00,
    ST_PUSH  = 2'b01,
    ST_FREED = 2'b10
  } rel_state_t;

endpackage : port_six_pkg

// file: rtl/port_six_pin_if.sv
// per-line pin control bundle between the port core and the pin mapper
interface port_six_pin_if;
  import port_six_pkg::*;
  logic [WIDTH-1:0] out_val;
  logic [WIDTH-1:0] drive;
  logic [WIDTH-1:0] odrain;
  logic [WIDTH-1:0] pad_out;
  logic [WIDTH-1:0] pad_oe;
  modport core   (output out_val, output drive, output odrain, input pad_out, input pad_oe);
  modport mapper (input out_val, input drive, input odrain, output pad_out, output pad_oe);
endinterface : port_six_pin_if

// file: rtl/port_six_pin_map.sv
// per-line driver: push/pull or open drain from value, enable and type
module port_six_pin_map (
  port_six_pin_if.mapper p  // line control bundle
);
  import port_six_pkg::*;

  // ***************************************************************
  // per line drivers
  // ***************************************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_line
      // open drain only pulls low; push/pull drives both levels
      assign p.pad_out[i] = p.odrain[i] ? 1'b0 : p.out_val[i];
      assign p.pad_oe[i]  = p.drive[i] & (~p.odrain[i] | ~p.out_val[i]);
    end
  endgenerate

endmodule // port_six_pin_map

// file: rtl/port_six_io.sv
// port six: general purpose lines with chip select and arbitration functions
//
// Decided for this implementation: the plain strobed port and the address map.
module port_six_io (
  input  wire logic                          clk,           // system clock
  input  wire logic                          rst,           // sync reset, high
  input  wire logic                          ce,            // clock enable
  input  wire logic [port_six_pkg::ADDR_W-1:0] addr,        // register index
  input  wire logic [port_six_pkg::WIDTH-1:0]  wdata,       // write data
  input  wire logic                          wr,            // write strobe
  input  wire logic                          rd,            // read strobe
  output logic      [port_six_pkg::WIDTH-1:0]  rdata,       // read data
  input  wire logic [1:0]                    strap_sel,     // select count straps
  input  wire logic [port_six_pkg::CS_LINES-1:0] window_cs, // selects from windows, low active
  input  wire logic                          arbitration_enable_bit, // from status word
  input  wire logic                          release_acknowledge_out, // bus released state
  input  wire logic                          bus_want_out,  // bus request from controller
  input  wire logic [port_six_pkg::WIDTH-1:0]  pin_in,      // pad levels
  output logic      [port_six_pkg::WIDTH-1:0]  pin_out,     // pad output value
  output logic      [port_six_pkg::WIDTH-1:0]  pin_oe,      // pad output enable
  output logic      [port_six_pkg::CS_LINES-1:0] pullup_en, // weak pullup enable
  output logic                               release_req    // release request to controller
);
  import port_six_pkg::*;

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic [WIDTH-1:0]    data;
    logic [WIDTH-1:0]    dir;
    logic [WIDTH-1:0]    odsel;
    select_count_field_t sel;
    logic                seen;
    rel_state_t          rel;
    logic [WIDTH-1:0]    rdata;
    logic [WIDTH-1:0]    pout;
    logic [WIDTH-1:0]    poe;
    logic [CS_LINES-1:0] pu;
    logic                relreq;
  } state_t;

  state_t s_q;
  state_t s_d;

  port_six_pin_if pins ();

  port_six_pin_map u_map (
    .p (pins.mapper)
  );

  // ***************************************************************
  // line function selection
  // ***************************************************************
  logic [CS_LINES-1:0]      cs_use;
  wire logic [WIDTH-1:0]    val;
  wire logic [WIDTH-1:0]    drv;
  wire logic [CS_LINES-1:0] pu_d;
  logic                     held;

  always_comb begin
    case (s_q.sel)
      SEL_NONE:  cs_use = 5'h00;
      SEL_TWO:   cs_use = 5'h03;
      SEL_THREE: cs_use = 5'h07;
      SEL_FIVE:  cs_use = 5'h1F;
      default:   cs_use = 5'h00;
    endcase
  end

  assign held = (s_q.rel != ST_OWN);

  // ***************************************************************
  // per line drivers: general purpose, select or arbitration
  // ***************************************************************
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_func
      if (g < CS_LINES) begin : g_sel
        // held select lines: one forced high cycle, then left to pullups where odsel is clear
        assign val[g]  = !cs_use[g] ? s_q.data[g]
                       : held       ? 1'b1
                       :              window_cs[g];
        assign drv[g]  = !cs_use[g] ? s_q.dir[g]
                       : held       ? (s_q.rel == ST_PUSH)
                       :              1'b1;
        assign pu_d[g] = cs_use[g] & held & ~s_q.odsel[g];
      end else if (g == LINE_REL) begin : g_rel
        assign val[g] = s_q.data[g];
        assign drv[g] = s_q.dir[g] & ~arbitration_enable_bit;
      end else if (g == LINE_ACK) begin : g_ack
        assign val[g] = arbitration_enable_bit ? release_acknowledge_out : s_q.data[g];
        assign drv[g] = arbitration_enable_bit | s_q.dir[g];
      end else begin : g_want
        assign val[g] = arbitration_enable_bit ? bus_want_out : s_q.data[g];
        assign drv[g] = arbitration_enable_bit | s_q.dir[g];
      end
    end
  endgenerate

  assign pins.out_val = val;
  assign pins.drive   = drv;
  assign pins.odrain  = (s_q.rel == ST_PUSH) ? 8'h00 : s_q.odsel;

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    s_d = s_q;
    if (!s_q.seen) begin
      s_d.sel  = select_count_field_t'(strap_sel);
      s_d.seen = 1'b1;
    end
    if (wr) begin
      case (addr)
        OFS_DATA:  s_d.data  = wdata;
        OFS_DIR:   s_d.dir   = wdata;
        OFS_ODSEL: s_d.odsel = wdata;
        default:   s_d.data  = s_q.data;
      endcase
    end
    case (s_q.rel)
      ST_OWN:   s_d.rel = release_acknowledge_out ? ST_PUSH : ST_OWN;
      ST_PUSH:  s_d.rel = release_acknowledge_out ? ST_FREED : ST_OWN;
      ST_FREED: s_d.rel = release_acknowledge_out ? ST_FREED : ST_OWN;
      default:  s_d.rel = ST_OWN;
    endcase
    s_d.rdata = 8'h00;
    if (rd) begin
      case (addr)
        OFS_DATA:   s_d.rdata = (s_q.data & s_q.dir) | (pin_in & ~s_q.dir);
        OFS_DIR:    s_d.rdata = s_q.dir;
        OFS_ODSEL:  s_d.rdata = s_q.odsel;
        OFS_STRAP:  s_d.rdata = {6'h00, s_q.sel};
        OFS_STATUS: s_d.rdata = {5'h00, held, s_q.rel == ST_PUSH, arbitration_enable_bit};
        default:    s_d.rdata = 8'h00;
      endcase
    end
    s_d.pout = pins.pad_out;
    s_d.poe  = pins.pad_oe;
    s_d.pu = pu_d;
    s_d.relreq = arbitration_enable_bit & ~pin_in[LINE_REL];
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q       <= '0;
      s_q.data  <= RST_DATA;
      s_q.dir   <= RST_DIR;
      s_q.odsel <= RST_ODSEL;
      s_q.sel   <= select_count_field_t'(RST_SEL);
      s_q.pu    <= 5'h1F;
      s_q.rel   <= ST_OWN;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign rdata     = s_q.rdata;
  assign pin_out   = s_q.pout;
  assign pin_oe    = s_q.poe;
  assign pullup_en = s_q.pu;
  assign release_req = s_q.relreq;

endmodule // port_six_io

// file: test/port_six_io_assertions.sv
// pin and read port checks for the port six block
module port_six_io_assertions (
  input wire logic       clk,                     // clock
  input wire logic       rst,                     // reset
  input wire logic       ce,                      // clock enable
  input wire logic [3:0] addr,                    // index
  input wire logic       rd,                      // read
  input wire logic [7:0] rdata,                   // read data
  input wire logic [1:0] strap_sel,               // straps
  input wire logic [4:0] window_cs,               // selects
  input wire logic       arbitration_enable_bit,  // arb on
  input wire logic       release_acknowledge_out, // released
  input wire logic [7:0] pin_in,                  // pads
  input wire logic [7:0] pin_out,                 // pad value
  input wire logic [7:0] pin_oe,                  // pad enable
  input wire logic [4:0] pullup_en,               // pullups
  input wire logic       release_req              // request
);
  timeunit 1ns;
  timeprecision 1ns;
  // select count as the block latches it at the first enabled edge
  logic       seen_q;
  logic [1:0] sel_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      seen_q <= 1'b0;
      sel_q  <= 2'h2;
    end else if (ce && !seen_q) begin
      seen_q <= 1'b1;
      sel_q  <= strap_sel;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  reset_pull_a: assert property (disable iff (1'b0) rst |=> pullup_en == 5'h1f && pin_oe == 8'h00)
    else $error("pins not quiet in reset");
  idle_read_a: assert property (ce && !rd |=> rdata == 8'h00)
    else $error("read data outside its slot");
  unmapped_read_a: assert property (ce && rd && addr > 4'h4 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  hold_in_a: assert property (!$past(rst) && ce && arbitration_enable_bit |=> !pin_oe[5])
    else $error("release request pin driven");
  release_req_a: assert property (!$past(rst) && ce |=> release_req ==
    ($past(arbitration_enable_bit) && !$past(pin_in[5]))) else $error("release request wrong");
  pull_off_a: assert property ((!release_acknowledge_out && ce) [*3] |=> pullup_en == 5'h00)
    else $error("pullup on while bus owned");
  cs_push_a: assert property (!$past(rst) && $rose(release_acknowledge_out) && sel_q != 2'h2
    |-> ##2 (pin_oe[0] && pin_out[0]) ##1 !pin_oe[0]) else $error("select push wrong");
  cs_follow_a: assert property ((!release_acknowledge_out && ce) [*4]
    ##0 sel_q != 2'h2 |=> (pin_oe[0] ? pin_out[0] : 1'b1) == $past(window_cs[0]))
    else $error("select 0 wrong");
  freeze_hold_a: assert property (!ce |=> $stable(pin_out) && $stable(pin_oe)
    && $stable(pullup_en) && $stable(rdata) && $stable(release_req))
    else $error("outputs moved while frozen");
endmodule : port_six_io_assertions

bind port_six_io port_six_io_assertions port_six_io_assertions_i (
  .clk(clk), .rst(rst), .ce(ce), .addr(addr), .rd(rd), .rdata(rdata), .strap_sel(strap_sel),
  .window_cs(window_cs), .arbitration_enable_bit(arbitration_enable_bit),
  .release_acknowledge_out(release_acknowledge_out), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe(pin_oe), .pullup_en(pullup_en), .release_req(release_req));

// file: test/port_six_far_model.sv
// pad side: wired-AND lines, weak pullups and a second master
module port_six_far_model (
  input  wire logic       clk,       // clock
  input  wire logic [7:0] pin_out,   // device value
  input  wire logic [7:0] pin_oe,    // device enable
  input  wire logic [4:0] pullup_en, // device pullups
  input  wire logic [7:0] ext_low,   // other master pulls low
  output logic      [7:0] pin_in     // line levels
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] lvl_q = 8'h00;
  logic [7:0] low;
  logic [7:0] high;
  assign low = (pin_oe & ~pin_out) | ext_low;
  assign high = (pin_oe | {3'b000, pullup_en}) & ~low;
  // an undriven line flips each cycle so a stale level never passes
  assign pin_in = high | (~low & ~lvl_q);
  always @(posedge clk) lvl_q <= pin_in;
endmodule : port_six_far_model

// file: test/port_six_io_test.sv
// self-checking bench for the port six block
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] t=%0t got %0h exp %0h", $time, g, e); end end
module port_six_io_test;
  timeunit 1ns;
  timeprecision 1ns;
  import port_six_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0, release_req;
  logic arbitration_enable_bit = 1'b0, release_acknowledge_out = 1'b0, bus_want_out = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, pin_in, pin_out, pin_oe, ext_low = 8'h00;
  logic [1:0] strap_sel = 2'b11;
  logic [4:0] window_cs = 5'h1f, pullup_en;
  logic [1:0] codes [4] = '{2'b10, 2'b01, 2'b00, 2'b11};
  logic [4:0] masks [4] = '{5'h00, 5'h03, 5'h07, 5'h1f};
  int miscompares = 0, total_checks = 0, cyc = 0;
  port_six_io port_six_io_i (
    .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .strap_sel(strap_sel), .window_cs(window_cs),
    .arbitration_enable_bit(arbitration_enable_bit),
    .release_acknowledge_out(release_acknowledge_out), .bus_want_out(bus_want_out),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
    .release_req(release_req));
  port_six_far_model port_six_far_model_i (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .ext_low(ext_low), .pin_in(pin_in));
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `CHK(rdata, e)
  endtask
  task automatic do_reset(input logic [1:0] s);
    @(posedge clk);
    strap_sel <= s;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    `CHK(pullup_en, 5'h1f)
    @(posedge clk);
    rst <= 1'b0;
    // straps move after the latching edge
    @(posedge clk);
    strap_sel <= ~s;
  endtask
  initial begin
    for (int i = 0; i < 4; i++) begin
      do_reset(codes[i]);
      settle();
      `CHK(pin_oe[4:0], masks[i])
      rd_reg(OFS_STRAP, {6'h00, codes[i]});
      rd_reg(OFS_DIR, RST_DIR);
      rd_reg(OFS_ODSEL, RST_ODSEL);
      rd_reg(4'hf, 8'h00);
    end
    wr_reg(OFS_STRAP, 8'h00);
    rd_reg(OFS_STRAP, 8'h03);
    $display("done: select count straps");
    wr_reg(OFS_DIR, 8'he0);
    wr_reg(OFS_DATA, 8'ha0);
    settle();
    `CHK(pin_oe[7:5], 3'b111)
    `CHK(pin_out[7:5], 3'b101)
    rd_reg(OFS_DATA, 8'hbf);
    wr_reg(OFS_ODSEL, 8'h22);
    window_cs <= 5'h1c;
    settle();
    `CHK(pin_oe, 8'hdf)
    `CHK(pin_out, 8'h9c)
    wr_reg(OFS_DIR, 8'h00);
    window_cs <= 5'h1f;
    ext_low <= 8'he2;
    settle();
    `CHK(pin_oe[7:5], 3'b000)
    rd_reg(OFS_DATA, 8'h1d);
    $display("done: general purpose lines");
    wr_reg(OFS_DIR, 8'he0);
    ext_low <= 8'h20;
    arbitration_enable_bit <= 1'b1;
    settle();
    `CHK(pin_oe[7:5], 3'b110)
    `CHK(pin_out[7:6], 2'b00)
    `CHK(release_req, 1'b1)
    rd_reg(OFS_STATUS, 8'h01);
    $display("done: arbitration");
    @(posedge clk);
    release_acknowledge_out <= 1'b1;
    bus_want_out <= 1'b1;
    ext_low <= 8'h21;
    settle();
    `CHK(pin_oe[4:0], 5'h00)
    `CHK(pullup_en, 5'h1d)
    `CHK(pin_out[7:6], 2'b11)
    rd_reg(OFS_STATUS, 8'h05);
    @(posedge clk);
    release_acknowledge_out <= 1'b0;
    settle();
    `CHK(pullup_en, 5'h00)
    $display("done: bus release");
    // a write while frozen must not land
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(OFS_DIR, 8'h55);
    ce <= 1'b1;
    rd_reg(OFS_DIR, 8'he0);
    $display("done: clock enable");
    end_sim();
  end
endmodule : port_six_io_test
